/* common/ptu_regs.vh */
// register offsets, field positions and reset values of the pin takeover unit
`ifndef PTU_REGS_VH
`define PTU_REGS_VH
// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define PTU_OFF_DIR    8'h00
`define PTU_OFF_STATE  8'h04
`define PTU_OFF_ASSIGN 8'h08
`define PTU_OFF_SLEEP  8'h0C
`define PTU_OFF_FLAG   8'h10
`define PTU_OFF_OWNER  8'h14
// ****************************************************************
// pin field positions
// ****************************************************************
`define PTU_NPINS      22
`define PTU_LCD_LO     0
`define PTU_LCD_HI     11
`define PTU_P1_TX      12
`define PTU_P1_RX      13
`define PTU_P2_TX      14
`define PTU_P2_RX      15
`define PTU_P3_TX      16
`define PTU_P3_RX      17
`define PTU_P4_TX      18
`define PTU_P4_RX      19
`define PTU_P4_CLK     20
`define PTU_P4_FRM     21
// ****************************************************************
// assignment register bits
// ****************************************************************
`define PTU_ASG_P1     0
`define PTU_ASG_P4     1
// ****************************************************************
// flag register bits
// ****************************************************************
`define PTU_FLG_HOLD   0
`define PTU_FLG_SLEEP  1
// ****************************************************************
// reset values
// ****************************************************************
`define PTU_DIR_RST    22'h000000
`define PTU_STATE_RST  22'h000000
`define PTU_ASG_RST    2'h0
`endif

/* rtl/ptu_sync_bank.v */
// two-flop synchroniser bank for the pad inputs
`timescale 1ns/100ps
module ptu_sync_bank #(
   parameter WIDTH = 22
) (
   input wire clk_sys,
   input wire rst,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;

   always @(posedge clk_sys) begin
      if (rst) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

/* rtl/ptu_pin_takeover_unit.v */
// pin takeover unit: peripheral pins as simple i/o, sleep pin control
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "ptu_regs.vh"
module ptu_pin_takeover_unit #(
   parameter NPINS = 22
) (
   input wire clk_sys,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire lcd_enable,
   input wire [3:0] port_tx_enable,
   input wire [3:0] port_rx_enable,
   input wire port4_sync_enable,
   input wire sleep_active,
   input wire peripheral_hold_bit,
   input wire [NPINS-1:0] periph_out,
   input wire [NPINS-1:0] periph_oe_n,
   input wire [NPINS-1:0] pad_in,
   output reg [NPINS-1:0] pad_out,
   output reg [NPINS-1:0] pad_oe_n,
   output reg [NPINS-1:0] periph_in,
   output reg [1:0] gpio_alt_route,
   output reg gpio_to_system
);
   // ****************************************************************
   // state
   // ****************************************************************
   reg [NPINS-1:0] pin_direction_reg;
   reg [NPINS-1:0] state_reg;
   reg [1:0] assign_reg;
   reg [NPINS-1:0] sleep_dir_reg;
   reg [NPINS-1:0] held_dir_reg;
   reg sleep_seen_reg;
   reg [31:0] rdata_next;
   wire [NPINS-1:0] pad_sync;
   wire [NPINS-1:0] owned;
   wire held;
   wire [NPINS-1:0] dir_next;
   wire [NPINS-1:0] state_next;

   function [NPINS-1:0] fit;
      input [31:0] w;
      begin
         fit = w[NPINS-1:0];
      end
   endfunction

   // ****************************************************************
   // pad input synchroniser
   // ****************************************************************
   ptu_sync_bank #(
      .WIDTH(NPINS)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(pad_in),
      .sync_out(pad_sync)
   );

   // ****************************************************************
   // ownership: pin is ours while its engine is off
   // ****************************************************************
   // usb port 0 pins are not in this map at all
   assign owned[`PTU_LCD_HI:`PTU_LCD_LO] = {12{~lcd_enable}};
   // tx and rx engines gate their own pin
   assign owned[`PTU_P1_TX] = ~port_tx_enable[0] | assign_reg[`PTU_ASG_P1];
   assign owned[`PTU_P1_RX] = ~port_rx_enable[0] | assign_reg[`PTU_ASG_P1];
   assign owned[`PTU_P2_TX] = ~port_tx_enable[1];
   assign owned[`PTU_P2_RX] = ~port_rx_enable[1];
   assign owned[`PTU_P3_TX] = ~port_tx_enable[2];
   assign owned[`PTU_P3_RX] = ~port_rx_enable[2];
   // port 4: reassign moves one engine to gpio, pins follow the other
   assign owned[`PTU_P4_TX] = ~port_tx_enable[3] & ~port4_sync_enable;
   assign owned[`PTU_P4_RX] = ~port_rx_enable[3] & ~port4_sync_enable;
   assign owned[`PTU_P4_CLK] = ~port4_sync_enable | assign_reg[`PTU_ASG_P4];
   assign owned[`PTU_P4_FRM] = ~port4_sync_enable | assign_reg[`PTU_ASG_P4];

   assign held = peripheral_hold_bit & ~sleep_active;

   // ****************************************************************
   // register writes
   // ****************************************************************
   assign dir_next = (reg_wr && reg_addr == `PTU_OFF_DIR) ?
      fit(reg_wdata) : pin_direction_reg;
   assign state_next = (reg_wr && reg_addr == `PTU_OFF_STATE) ?
      fit(reg_wdata) : state_reg;

   always @(posedge clk_sys) begin
      if (rst || sleep_active) begin
         // peripheral reset on sleep entry clears normal registers
         pin_direction_reg <= `PTU_DIR_RST;
         state_reg <= `PTU_STATE_RST;
         assign_reg <= `PTU_ASG_RST;
      end else begin
         pin_direction_reg <= dir_next;
         state_reg <= state_next;
         if (reg_wr && reg_addr == `PTU_OFF_ASSIGN) begin
            assign_reg <= reg_wdata[1:0];
         end
      end
   end

   // sleep direction register has no reset term
   always @(posedge clk_sys) begin
      if (reg_wr && reg_addr == `PTU_OFF_SLEEP) begin
         sleep_dir_reg <= fit(reg_wdata);
      end
   end

   // remembers sleep directions for the hold period after wake
   always @(posedge clk_sys) begin
      if (rst) begin
         held_dir_reg <= {NPINS{1'b0}};
         sleep_seen_reg <= 1'b0;
      end else begin
         if (sleep_active) begin
            held_dir_reg <= sleep_dir_reg;
            sleep_seen_reg <= 1'b1;
         end else if (reg_wr && reg_addr == `PTU_OFF_FLAG &&
                      reg_wdata[`PTU_FLG_SLEEP]) begin
            sleep_seen_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // pad drive; plain levels only, no edge logic
   // ****************************************************************
   integer i;
   always @(posedge clk_sys) begin
      if (rst) begin
         pad_out <= {NPINS{1'b0}};
         pad_oe_n <= {NPINS{1'b1}};
         periph_in <= {NPINS{1'b0}};
         gpio_alt_route <= 2'h0;
         gpio_to_system <= 1'b1;
      end else begin
         for (i = 0; i < NPINS; i = i + 1) begin
            if (sleep_active) begin
               pad_out[i] <= 1'b0;
               pad_oe_n[i] <= ~sleep_dir_reg[i];
            end else if (held) begin
               pad_out[i] <= 1'b0;
               pad_oe_n[i] <= ~held_dir_reg[i];
            end else if (owned[i]) begin
               pad_out[i] <= state_reg[i];
               pad_oe_n[i] <= ~pin_direction_reg[i];
            end else begin
               pad_out[i] <= periph_out[i];
               pad_oe_n[i] <= periph_oe_n[i];
            end
            periph_in[i] <= owned[i] ? 1'b0 : pad_sync[i];
         end
         gpio_alt_route <= sleep_active ? 2'h0 : assign_reg;
         gpio_to_system <= sleep_active | (assign_reg == 2'h0);
      end
   end

   // ****************************************************************
   // register reads, data one cycle after strobe
   // ****************************************************************
   always @* begin
      rdata_next = 32'h00000000;
      case (reg_addr)
         `PTU_OFF_DIR: rdata_next[NPINS-1:0] = pin_direction_reg;
         `PTU_OFF_STATE: begin
            // outputs read back the latch, inputs the pad
            rdata_next[NPINS-1:0] = (state_reg & pin_direction_reg) |
               (pad_sync & ~pin_direction_reg);
         end
         `PTU_OFF_ASSIGN: rdata_next[1:0] = assign_reg;
         `PTU_OFF_SLEEP: rdata_next[NPINS-1:0] = sleep_dir_reg;
         `PTU_OFF_FLAG: begin
            rdata_next[`PTU_FLG_HOLD] = held;
            rdata_next[`PTU_FLG_SLEEP] = sleep_seen_reg;
         end
         `PTU_OFF_OWNER: rdata_next[NPINS-1:0] = owned;
         default: rdata_next = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule

/* bench/ptu_pads_model.sv */
// far-side devices wired to the peripheral pins
`timescale 1ns/100ps
module ptu_pads_model #(parameter NPINS = 22) (
   input wire [NPINS-1:0] pad_out,
   input wire [NPINS-1:0] pad_oe_n,
   input wire [NPINS-1:0] ext_val,
   output wire [NPINS-1:0] pad_in
);
   // chip driver wins on its pins, far device drives the rest
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_val);
endmodule

/* bench/ptu_pin_takeover_unit_sva.sv */
// port checker for the pin takeover unit
`timescale 1ns/100ps
module ptu_chk #(parameter NPINS = 22) (
   input wire clk_sys,
   input wire rst,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire lcd_enable,
   input wire [3:0] port_tx_enable,
   input wire sleep_active,
   input wire peripheral_hold_bit,
   input wire [NPINS-1:0] periph_oe_n,
   input wire [NPINS-1:0] pad_out,
   input wire [NPINS-1:0] pad_oe_n,
   input wire [1:0] gpio_alt_route,
   input wire gpio_to_system
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_lcd_run;
      (lcd_enable && !sleep_active && !peripheral_hold_bit) [*2];
   endsequence
   sequence s_tx1_run;
      (port_tx_enable[0] && !sleep_active && !peripheral_hold_bit
         && gpio_alt_route == 2'h0) [*3];
   endsequence
   sequence s_held;
      (peripheral_hold_bit && !sleep_active) [*2];
   endsequence
   AST_RST_IN: assert property (disable iff (1'b0) rst |=> &pad_oe_n)
      else $error("pins not inputs after reset");
   AST_LCD_OWN: assert property (s_lcd_run |->
      pad_oe_n[11:0] == $past(periph_oe_n[11:0])) else $error("lcd pins");
   AST_TX1_OWN: assert property (s_tx1_run |->
      pad_oe_n[12] == $past(periph_oe_n[12])) else $error("port1 tx pin");
   AST_SLEEP_LOW: assert property (sleep_active [*2] |->
      (pad_out & ~pad_oe_n) == '0) else $error("sleep output high");
   AST_HOLD_KEEP: assert property (s_held |-> $stable(pad_oe_n)
      && (pad_out & ~pad_oe_n) == '0) else $error("hold lost pins");
   AST_ROUTE_SLEEP: assert property (sleep_active |=>
      gpio_alt_route == 2'h0 && gpio_to_system) else $error("route in sleep");
   AST_ROUTE_SYS: assert property (
      gpio_to_system == (gpio_alt_route == 2'h0)) else $error("gpio owner");
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data without read");
endmodule
bind ptu_pin_takeover_unit ptu_chk #(.NPINS(NPINS)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .lcd_enable(lcd_enable), .port_tx_enable(port_tx_enable),
   .sleep_active(sleep_active), .peripheral_hold_bit(peripheral_hold_bit),
   .periph_oe_n(periph_oe_n), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
   .gpio_alt_route(gpio_alt_route), .gpio_to_system(gpio_to_system));

/* bench/test_peripheral_pin_controller.sv */
// self-checking bench for the pin takeover unit
`timescale 1ns/100ps
`include "ptu_regs.vh"
module test_peripheral_pin_controller;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg reg_wr = 1'b0, reg_rd = 1'b0, lcd_en = 1'b0, sleep = 1'b0, hold = 1'b0;
   reg p4_en = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h00000000;
   reg [3:0] tx_en = 4'h0, rx_en = 4'h0;
   reg [21:0] p_out = 22'h000000, p_oe_n = 22'h3FFFFF, ext = 22'h000000;
   wire [21:0] pad_in, pad_out, pad_oe_n, periph_in;
   wire [31:0] rdata;
   wire [1:0] route;
   wire to_sys;
   integer errors = 0, n_tests = 0;
   always #2 clk_sys = ~clk_sys;
   ptu_pin_takeover_unit dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
      .lcd_enable(lcd_en), .port_tx_enable(tx_en), .port_rx_enable(rx_en),
      .port4_sync_enable(p4_en), .sleep_active(sleep),
      .peripheral_hold_bit(hold), .periph_out(p_out), .periph_oe_n(p_oe_n),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .periph_in(periph_in), .gpio_alt_route(route), .gpio_to_system(to_sys));
   ptu_pads_model far (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_val(ext),
      .pad_in(pad_in));
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task wt(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_sys);
         reg_wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clk_sys);
         reg_rd <= 1'b1;
         addr <= a;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1;
         chk("rdata", exp, rdata);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d errors %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task t_reset;
      begin
         wt(1);
         chk("oe_n", 32'h3FFFFF, pad_oe_n);
         rd(`PTU_OFF_DIR, 32'h0);
         rd(`PTU_OFF_OWNER, 32'h3FFFFF);
         rd(8'h18, 32'h0);
      end
   endtask
   task t_gpio;
      begin
         @(posedge clk_sys);
         ext <= 22'h2AAAAA;
         // unused pins set up as plain i/o right after reset
         wr(`PTU_OFF_DIR, 32'h0F0F0F);
         wr(`PTU_OFF_STATE, 32'h333333);
         wt(3);
         chk("oe_n", 32'h30F0F0, pad_oe_n);
         chk("out", 32'h030303, pad_out & 22'h0F0F0F);
         rd(`PTU_OFF_STATE, 32'h23A3A3);
      end
   endtask
   task t_owned;
      begin
         @(posedge clk_sys);
         lcd_en <= 1'b1;
         tx_en <= 4'h1;
         p_oe_n <= 22'h000000;
         p_out <= 22'h001ABC;
         wt(3);
         chk("oe_n", 32'h30E000, pad_oe_n);
         chk("out", 32'h1ABC, pad_out & 22'h001FFF);
         rd(`PTU_OFF_OWNER, 32'h3FE000);
         chk("periph_in", 32'h001ABC, periph_in);
      end
   endtask
   task t_route;
      begin
         wr(`PTU_OFF_ASSIGN, 32'h1);
         wt(2);
         chk("route", 32'h1, {to_sys, route});
         chk("tx1", 32'h1, pad_oe_n[12]);
         wr(`PTU_OFF_ASSIGN, 32'h2);
         wt(2);
         chk("route", 32'h2, {to_sys, route});
      end
   endtask
   task t_sleep;
      begin
         wr(`PTU_OFF_SLEEP, 32'h00000F);
         @(posedge clk_sys);
         rst <= 1'b1;
         @(posedge clk_sys);
         rst <= 1'b0;
         rd(`PTU_OFF_SLEEP, 32'h00000F);
         @(posedge clk_sys);
         sleep <= 1'b1;
         wt(3);
         chk("oe_n", 32'h3FFFF0, pad_oe_n);
         chk("out", 32'h0, pad_out);
         chk("route", 32'h4, {to_sys, route});
         @(posedge clk_sys);
         sleep <= 1'b0;
         hold <= 1'b1;
         wt(3);
         chk("oe_n", 32'h3FFFF0, pad_oe_n);
         @(posedge clk_sys);
         hold <= 1'b0;
         wt(3);
         chk("own", 32'h3FE000, pad_oe_n);
         rd(`PTU_OFF_FLAG, 32'h2);
         wr(`PTU_OFF_FLAG, 32'h2);
         rd(`PTU_OFF_FLAG, 32'h0);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_gpio;
      t_owned;
      t_route;
      t_sleep;
      give_verdict;
   end
   initial begin
      #20000;
      errors = errors + 1;
      give_verdict;
   end
endmodule
